/* File: design/seq_prog_map.svh */
// Offsets, reset values, timing counts and command codes of the sequential program controller
`ifndef SEQ_PROG_MAP_SVH
`define SEQ_PROG_MAP_SVH
`define CLK_PERIOD_NS 5
`define BYTE_PROG_TIME_NS 20000
`define BYTE_PROG_CYC ((`BYTE_PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ARRAY_LAST_ADDR 24'h03ffff
`define ADDR_LAST_IDX 2'h2
`define STAT_ONE_BUSY_BIT 0
`define STAT_ONE_LATCH_BIT 1
`define LATCH_RST 1'b0
`define SEQ_RST 1'b0
`define BUSY_RST 1'b0
`define CMD_SEQ_A 8'had
`define CMD_SEQ_B 8'haf
`define CMD_WREN 8'h06
`define CMD_WRDI 8'h04
`define CMD_TERM 8'hf0
`define CMD_RST_EN 8'h66
`define CMD_RST 8'h99
`define CMD_SR_A 8'h05
`define CMD_SR_B 8'h35
`define CMD_SR_C 8'h15
`define CMD_SR_IND 8'h65
`define CMD_ACT_INT 8'h25
`define CMD_ID_A 8'h9f
`define CMD_ID_B 8'h90
`define CMD_ID_C 8'h94
`endif

/* File: design/seq_prog_pkg.sv */
// Types shared by the serial receiver and the sequential program controller
`default_nettype none
package seq_prog_pkg;
    typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_ADDR, PH_DATA, PH_SKIP} phase_t;
    typedef enum logic [1:0] {P_IDLE, P_RUN, P_CHK} prog_t;
    typedef struct packed {
        logic cs1, cs2, cs3;
        logic ck1, ck2, ck3;
        logic si1, si2;
        logic [7:0] sh;
        logic [2:0] bit_pos;
        logic [7:0] byte_val;
        logic byte_stb, sel_fall, sel_rise;
    } rx_t;
    typedef struct packed {
        phase_t ph;
        prog_t pst;
        logic [7:0] cmd;
        logic cmd_ok;
        logic [1:0] abytes;
        logic [23:0] addr;
        logic [7:0] data;
        logic got_data, initial_xfer;
        logic wlatch, seq, busy;
        logic [15:0] tmr;
        logic rst_armed;
        logic acc, rej, start;
    } ctrl_t;
endpackage : seq_prog_pkg
`default_nettype wire

/* File: design/spi_link_if.sv */
// Byte and chip-select events passed from the serial receiver to the controller
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
    logic byte_stb;
    logic [7:0] byte_val;
    logic [2:0] bit_pos;
    logic sel_fall;
    logic sel_rise;
    modport src(output byte_stb, output byte_val, output bit_pos, output sel_fall, output sel_rise);
    modport dst(input byte_stb, input byte_val, input bit_pos, input sel_fall, input sel_rise);
endinterface : spi_link_if
`default_nettype wire

/* File: design/spi_bit_rx.sv */
// Synchronises the serial pins and assembles MSB-first bytes
`timescale 1ns/1ps
`default_nettype none
module spi_bit_rx
    import seq_prog_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    spi_link_if.src lk
);
    rx_t q, n;

    always_comb begin
        n = q;
        n.byte_stb = 1'b0;
        n.sel_fall = 1'b0;
        n.sel_rise = 1'b0;
        n.cs1 = spi_cs_n;
        n.cs2 = q.cs1;
        n.cs3 = q.cs2;
        n.ck1 = spi_sclk;
        n.ck2 = q.ck1;
        n.ck3 = q.ck2;
        n.si1 = spi_si;
        n.si2 = q.si1;
        // Modes 0 and 3 both sample on the rising clock edge
        if (!q.cs2 && q.ck2 && !q.ck3) begin
            n.sh = {q.sh[6:0], q.si2};
            n.bit_pos = q.bit_pos + 3'h1;
            if (q.bit_pos == 3'h7) begin
                n.byte_val = {q.sh[6:0], q.si2};
                n.byte_stb = 1'b1;
            end
        end
        if (q.cs3 && !q.cs2) begin
            n.sel_fall = 1'b1;
            n.bit_pos = 3'h0;
        end
        if (!q.cs3 && q.cs2) begin
            n.sel_rise = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.cs1 <= 1'b1;
            q.cs2 <= 1'b1;
            q.cs3 <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign lk.byte_stb = q.byte_stb;
    assign lk.byte_val = q.byte_val;
    assign lk.bit_pos = q.bit_pos;
    assign lk.sel_fall = q.sel_fall;
    assign lk.sel_rise = q.sel_rise;
endmodule : spi_bit_rx
`default_nettype wire

/* File: design/seq_prog_ctrl.sv */
// Sequential program mode controller: command gating, address counter and self-timed byte program
`timescale 1ns/1ps
`default_nettype none
`include "seq_prog_map.svh"
// Summary of operation
// - While busy, ignore all commands except a small permitted set.
// - Idle in mode: accept status reads, active interrupt and identification reads.
// - Idle in mode: accept sequential program, write enable/disable, terminate, reset pair.
// - In mode: reject array/buffer reads and writes, erases, byte/page programs.
// - In mode: reject suspend, resume, locks, OTP, status writes, power-down, misc.
// - Several data bytes in one cycle: only the last byte is programmed.
// - Chip select rising off a byte boundary or without data aborts and clears latch.
// - Protected initial address: no program, back to idle, latch cleared.
// - Counter entering protected block ends the mode and clears the latch.
// - No wrap: after the last array location the mode ends, latch cleared.
// - Counter entering a block with suspended erase ends the mode.
// - Write latch cleared for any reason ends the mode.
// - Busy flag in status register one is set during each byte program.
// - First transfer: command, 24-bit address, data; later: command and data only.
// - Write enable not needed per byte; write disable ends the mode.
module seq_prog_ctrl
    import seq_prog_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    input wire logic addr_protected,
    input wire logic erase_susp,
    input wire logic [7:0] susp_blk,
    output logic device_busy_flag,
    output logic write_latch_flag,
    output logic seq_prog_active_flag,
    output logic [7:0] status_reg_one,
    output logic prog_start,
    output logic [23:0] prog_addr,
    output logic [7:0] prog_data,
    output logic cmd_accepted,
    output logic cmd_rejected,
    output logic [7:0] cmd_code
);
    spi_link_if lk();

    spi_bit_rx u_rx (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_si(spi_si),
        .lk(lk)
    );

    function automatic logic busy_ok(input logic [7:0] c);
        case (c)
            `CMD_SR_A, `CMD_SR_B, `CMD_SR_C, `CMD_SR_IND, `CMD_ACT_INT, `CMD_RST_EN, `CMD_RST: busy_ok = 1'b1;
            default: busy_ok = 1'b0;
        endcase
    endfunction : busy_ok

    function automatic logic seq_ok(input logic [7:0] c);
        case (c)
            `CMD_SR_A, `CMD_SR_B, `CMD_SR_C, `CMD_SR_IND, `CMD_ACT_INT,
            `CMD_ID_A, `CMD_ID_B, `CMD_ID_C,
            `CMD_SEQ_A, `CMD_SEQ_B, `CMD_WREN, `CMD_WRDI, `CMD_TERM, `CMD_RST_EN, `CMD_RST: seq_ok = 1'b1;
            default: seq_ok = 1'b0;
        endcase
    endfunction : seq_ok

    ctrl_t q, n;
    logic allow;
    logic is_seq_cmd;
    logic prog_done;

    assign allow = q.busy ? busy_ok(lk.byte_val) : (q.seq ? seq_ok(lk.byte_val) : 1'b1);
    assign is_seq_cmd = (lk.byte_val == `CMD_SEQ_A) || (lk.byte_val == `CMD_SEQ_B);
    assign prog_done = (q.pst == P_RUN) && (q.tmr == 16'(`BYTE_PROG_CYC - 1));

    always_comb begin
        n = q;
        n.acc = 1'b0;
        n.rej = 1'b0;
        n.start = 1'b0;
        if (lk.sel_fall) begin
            n.ph = PH_CMD;
        end
        if (lk.byte_stb) begin
            case (q.ph)
                PH_CMD: begin
                    n.cmd = lk.byte_val;
                    n.cmd_ok = allow;
                    n.ph = PH_SKIP;
                    if (!allow) begin
                        n.rej = 1'b1;
                    end else begin
                        n.acc = 1'b1;
                        if (is_seq_cmd && !q.busy) begin
                            if (q.seq) begin
                                n.ph = PH_DATA;
                                n.initial_xfer = 1'b0;
                                n.got_data = 1'b0;
                            end else if (q.wlatch) begin
                                n.ph = PH_ADDR;
                                n.abytes = 2'h0;
                                n.initial_xfer = 1'b1;
                                n.got_data = 1'b0;
                            end
                        end
                    end
                end
                PH_ADDR: begin
                    n.addr = {q.addr[15:0], lk.byte_val};
                    n.abytes = q.abytes + 2'h1;
                    if (q.abytes == `ADDR_LAST_IDX) begin
                        n.ph = PH_DATA;
                    end
                end
                PH_DATA: begin
                    // Later bytes overwrite earlier ones
                    n.data = lk.byte_val;
                    n.got_data = 1'b1;
                end
                default: begin
                end
            endcase
        end
        if (lk.sel_rise) begin
            n.ph = PH_IDLE;
            case (q.ph)
                PH_ADDR, PH_DATA: begin
                    if (!q.got_data || lk.bit_pos != 3'h0) begin
                        n.wlatch = 1'b0;
                    end else if (q.initial_xfer && addr_protected) begin
                        n.wlatch = 1'b0;
                    end else begin
                        n.seq = 1'b1;
                        n.busy = 1'b1;
                        n.pst = P_RUN;
                        n.tmr = 16'h0000;
                        n.start = 1'b1;
                    end
                end
                PH_SKIP: begin
                    // Only commands ending on a byte boundary act; frame length is not checked
                    if (q.cmd_ok && lk.bit_pos == 3'h0) begin
                        n.rst_armed = (q.cmd == `CMD_RST_EN);
                        case (q.cmd)
                            `CMD_WREN: n.wlatch = 1'b1;
                            `CMD_WRDI: n.wlatch = 1'b0;
                            `CMD_TERM: n.seq = 1'b0;
                            `CMD_RST: begin
                                if (q.rst_armed) begin
                                    n.wlatch = 1'b0;
                                    n.seq = 1'b0;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                default: begin
                end
            endcase
        end
        case (q.pst)
            P_RUN: begin
                n.tmr = q.tmr + 16'h0001;
                if (prog_done) begin
                    if (q.addr == `ARRAY_LAST_ADDR) begin
                        n.seq = 1'b0;
                        n.wlatch = 1'b0;
                        n.busy = 1'b0;
                        n.pst = P_IDLE;
                    end else begin
                        n.addr = q.addr + 24'h000001;
                        n.pst = P_CHK;
                    end
                end
            end
            P_CHK: begin
                // Protection input follows the incremented counter one cycle later
                n.busy = 1'b0;
                n.pst = P_IDLE;
                if (addr_protected) begin
                    n.seq = 1'b0;
                    n.wlatch = 1'b0;
                end
                if (erase_susp && q.addr[23:16] == susp_blk) begin
                    n.seq = 1'b0;
                end
            end
            default: begin
            end
        endcase
        if (!n.wlatch) begin
            n.seq = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.ph <= PH_IDLE;
            q.pst <= P_IDLE;
            q.wlatch <= `LATCH_RST;
            q.seq <= `SEQ_RST;
            q.busy <= `BUSY_RST;
        end else begin
            q <= n;
        end
    end

    always_comb begin
        status_reg_one = 8'h00;
        status_reg_one[`STAT_ONE_BUSY_BIT] = q.busy;
        status_reg_one[`STAT_ONE_LATCH_BIT] = q.wlatch;
    end
    assign device_busy_flag = q.busy;
    assign write_latch_flag = q.wlatch;
    assign seq_prog_active_flag = q.seq;
    assign prog_start = q.start;
    assign prog_addr = q.addr;
    assign prog_data = q.data;
    assign cmd_accepted = q.acc;
    assign cmd_rejected = q.rej;
    assign cmd_code = q.cmd;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_prog_begin;
        $rose(q.busy);
    endsequence
    sequence s_prog_hold;
        q.busy [*8];
    endsequence

    a_busy_cmd_drop: assert property ((lk.byte_stb && q.ph == PH_CMD && q.busy && !busy_ok(lk.byte_val))
        |=> (cmd_rejected && !cmd_accepted)) else $error("busy command not rejected");
    a_seq_cmd_pass: assert property ((lk.byte_stb && q.ph == PH_CMD && !q.busy && q.seq && seq_ok(lk.byte_val))
        |=> cmd_accepted) else $error("permitted command refused in mode");
    a_seq_cmd_block: assert property ((lk.byte_stb && q.ph == PH_CMD && !q.busy && q.seq && !seq_ok(lk.byte_val))
        |=> (cmd_rejected && seq_prog_active_flag == $past(q.seq))) else $error("forbidden command let in");
    a_short_abort: assert property ((lk.sel_rise && q.ph == PH_DATA && !q.got_data)
        |=> (!write_latch_flag && !prog_start && !seq_prog_active_flag)) else $error("short frame not aborted");
    a_prot_entry: assert property ((lk.sel_rise && q.ph == PH_DATA && q.got_data && lk.bit_pos == 3'h0
        && q.initial_xfer && addr_protected) |=> (!write_latch_flag && !device_busy_flag))
        else $error("protected entry programmed");
    a_prot_leave: assert property ((q.pst == P_CHK && addr_protected)
        |=> (!seq_prog_active_flag && !write_latch_flag)) else $error("mode kept at protected block");
    a_last_addr: assert property ((prog_done && q.addr == `ARRAY_LAST_ADDR)
        |=> (!seq_prog_active_flag && !write_latch_flag && prog_addr == `ARRAY_LAST_ADDR))
        else $error("counter wrapped past array end");
    a_susp_leave: assert property ((q.pst == P_CHK && erase_susp && q.addr[23:16] == susp_blk)
        |=> !seq_prog_active_flag) else $error("mode kept in suspended block");
    a_wel_ends_seq: assert property ($fell(write_latch_flag) |-> !seq_prog_active_flag)
        else $error("mode outlived write latch");
    a_busy_hold: assert property (s_prog_begin |-> s_prog_hold)
        else $error("program busy too short");
    a_start_busy: assert property (prog_start |-> (device_busy_flag && status_reg_one[`STAT_ONE_BUSY_BIT]))
        else $error("program started without busy");
endmodule : seq_prog_ctrl
`default_nettype wire

/* File: verification/spi_host_model.sv */
// Host side of the serial link: frames MSB-first bytes on a 64 ns serial clock
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input wire logic clk_sys,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_si
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_si = 1'b0;
    end

    // Sends the top nbits of v; the clock stands still between frames
    task automatic xfer(input logic [39:0] v, input int nbits);
        // Whole-ns pin edges never meet the half-ns sampling edges
        @(negedge clk_sys);
        spi_cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            spi_si = v[39 - i];
            #32;
            spi_sclk = 1'b1;
            #32;
            spi_sclk = 1'b0;
        end
        // Released data line shows the inverse, not a stale bit
        spi_si = ~spi_si;
        #32;
        spi_cs_n = 1'b1;
        #64;
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire

/* File: verification/tb_seq_prog_ctrl.sv */
// Self-checking bench for the sequential program controller
`timescale 1ns/1ps
`default_nettype none
module tb_seq_prog_ctrl;
    logic clk_sys = 1'b0, rst_n = 1'b0, prot_all = 1'b0, erase_susp = 1'b0;
    logic [7:0] prot_blk = 8'hff, susp_blk = 8'h00;
    logic spi_sclk, spi_cs_n, spi_si, addr_protected, busy, wlatch, mode, prog_start, acc, rej;
    logic [7:0] status_reg_one, prog_data, cmd_code;
    logic [23:0] prog_addr;
    int n_fail = 0, check_count = 0, n_acc = 0, n_rej = 0, n_ps = 0, n_bsy = 0, a0, r0, p0, b0;
    logic [7:0] ok_rd[8] = '{8'h05, 8'h35, 8'h15, 8'h65, 8'h25, 8'h9f, 8'h90, 8'h94};
    logic [7:0] bad[44] = '{8'h03, 8'h3b, 8'h6b, 8'heb, 8'he7, 8'h0b, 8'hd4, 8'h81, 8'hdb, 8'h20, 8'h52,
        8'hd8, 8'h60, 8'hc7, 8'h84, 8'h02, 8'ha2, 8'h32, 8'h88, 8'h0a, 8'hb0, 8'h75, 8'hd0, 8'h7a, 8'h50,
        8'h36, 8'h39, 8'h7e, 8'h98, 8'h3c, 8'h3d, 8'h9b, 8'h4b, 8'h01, 8'h31, 8'h11, 8'h71, 8'h6f, 8'hb9,
        8'hab, 8'h79, 8'h5a, 8'h77, 8'hef};

    always #2.5 clk_sys = ~clk_sys;
    assign addr_protected = prot_all | (prog_addr[23:16] == prot_blk);

    spi_host_model h (.clk_sys(clk_sys), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si));

    seq_prog_ctrl i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_si(spi_si), .addr_protected(addr_protected), .erase_susp(erase_susp), .susp_blk(susp_blk),
        .device_busy_flag(busy), .write_latch_flag(wlatch), .seq_prog_active_flag(mode),
        .status_reg_one(status_reg_one), .prog_start(prog_start), .prog_addr(prog_addr),
        .prog_data(prog_data), .cmd_accepted(acc), .cmd_rejected(rej), .cmd_code(cmd_code));

    // One-cycle pulses and busy cycles are tallied here so scenarios can compare counts
    always @(posedge clk_sys) begin
        if (acc === 1'b1) n_acc++;
        if (rej === 1'b1) n_rej++;
        if (prog_start === 1'b1) n_ps++;
        if (busy === 1'b1) n_bsy++;
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    task automatic cmd(input logic [7:0] c);
        h.xfer({c, 32'h0}, 8);
    endtask : cmd

    task automatic enter(input logic [23:0] a, input logic [7:0] d);
        cmd(8'h06);
        h.xfer({8'had, a, d}, 40);
    endtask : enter

    // Polls busy instead of waiting the worst case program time
    task automatic wait_idle;
        int i;
        for (i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge clk_sys);
        if (i == 5000) begin
            n_fail++;
            finish_test();
        end
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : wait_idle

    task automatic flags(input logic m, input logic w);
        check(24'(mode), 24'(m));
        check(24'(wlatch), 24'(w));
    endtask : flags

    initial begin
        repeat (2) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        flags(1'b0, 1'b0);
        check(24'(status_reg_one), 24'h0);
        p0 = n_ps;
        enter(24'h03fffe, 8'h11);
        check(24'(n_ps - p0), 24'h1);
        check({busy, wlatch, mode}, 24'h7);
        check(24'(status_reg_one), 24'h3);
        check(prog_addr, 24'h03fffe);
        check(24'(prog_data), 24'h11);
        a0 = n_acc;
        r0 = n_rej;
        h.xfer({8'h05, 32'h0}, 16);
        cmd(8'h02);
        cmd(8'had);
        check(24'(n_acc - a0), 24'h1);
        check(24'(n_rej - r0), 24'h2);
        wait_idle();
        check(prog_addr, 24'h03ffff);
        flags(1'b1, 1'b1);
        h.xfer({8'haf, 8'h22, 8'h33, 16'h0}, 24);
        check(24'(prog_data), 24'h33);
        wait_idle();
        flags(1'b0, 1'b0);
        b0 = n_bsy;
        enter(24'h000010, 8'h44);
        wait_idle();
        // Byte time of 4000 cycles plus the one exit check cycle
        check(24'(n_bsy - b0), 24'd4001);
        a0 = n_acc;
        foreach (ok_rd[k]) h.xfer({ok_rd[k], 32'h0}, 16);
        cmd(8'h06);
        check(24'(n_acc - a0), 24'd9);
        r0 = n_rej;
        foreach (bad[k]) cmd(bad[k]);
        check(24'(n_rej - r0), 24'd44);
        check(prog_addr, 24'h000011);
        flags(1'b1, 1'b1);
        cmd(8'hf0);
        check(24'(cmd_code), 24'hf0);
        flags(1'b0, 1'b1);
        enter(24'h000020, 8'h55);
        wait_idle();
        p0 = n_ps;
        h.xfer({8'had, 4'h5, 28'h0}, 12);
        check(24'(n_ps - p0), 24'h0);
        flags(1'b0, 1'b0);
        enter(24'h000030, 8'h66);
        wait_idle();
        cmd(8'h04);
        flags(1'b0, 1'b0);
        enter(24'h000040, 8'h67);
        wait_idle();
        cmd(8'h66);
        cmd(8'h99);
        flags(1'b0, 1'b0);
        @(posedge clk_sys);
        #1 prot_all = 1'b1;
        p0 = n_ps;
        enter(24'h000050, 8'h77);
        check(24'(n_ps - p0), 24'h0);
        flags(1'b0, 1'b0);
        @(posedge clk_sys);
        #1 prot_all = 1'b0;
        prot_blk = 8'h01;
        enter(24'h00ffff, 8'h88);
        wait_idle();
        flags(1'b0, 1'b0);
        @(posedge clk_sys);
        #1 prot_blk = 8'hff;
        erase_susp = 1'b1;
        susp_blk = 8'h02;
        enter(24'h01ffff, 8'h99);
        wait_idle();
        check(24'(mode), 24'h0);
        finish_test();
    end
endmodule : tb_seq_prog_ctrl
`default_nettype wire
